/* File: rtl/urs_pkg.sv */
// package of constants for the uart receive status block
package urs_pkg;
  // register map (word indexes on the plain register port)
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MODE = 4'h1;
  localparam logic [3:0] ADDR_RXDATA = 4'h2;
  localparam logic [3:0] ADDR_INT_STATUS = 4'h3;
  localparam logic [3:0] ADDR_INT_MASK = 4'h4;
  // status register field positions
  localparam int BIT_ADDR_DETECT_EN = 5;
  localparam int BIT_RX_IDLE = 4;
  localparam int BIT_PARITY_ERR = 3;
  localparam int BIT_FRAMING_ERR = 2;
  localparam int BIT_OVERRUN = 1;
  localparam int BIT_DATA_AVAIL = 0;
  // address character marker position in a 9-bit character
  localparam int BIT_ADDR_MARK = 8;
  // character length selection
  localparam logic [1:0] MODE_8BIT_NONE = 2'h0;
  localparam logic [1:0] MODE_8BIT_EVEN = 2'h1;
  localparam logic [1:0] MODE_8BIT_ODD = 2'h2;
  localparam logic [1:0] MODE_9BIT = 2'h3;
  // interrupt status bits
  localparam int IRQ_RX_CHAR = 0;
  localparam int IRQ_ADDR_CHAR = 1;
  localparam int IRQ_OVERRUN = 2;
  localparam int IRQ_ERROR = 3;
  localparam int IRQ_WIDTH = 4;
  // fifo and bit timing
  localparam int FIFO_DEPTH = 4;
  localparam int PTR_WIDTH = 2;
  localparam int ENTRY_WIDTH = 11;
  localparam logic [15:0] RESET_DIVISOR = 16'h0056;
  localparam logic [15:0] RESET_STATUS = 16'h0010;
endpackage : urs_pkg

/* File: rtl/urs_uart_receive_status.sv */
// receive path, status register and interrupt logic of an asynchronous serial port
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - in address detect mode a character with bit 8 set is an address character
// - address detect acts only in 9-bit mode; clearing it turns detection off
// - read-only idle flag is 1 when idle, 0 while a character is received
// - parity error flag shows the state of the head fifo character
// - framing error flag shows the state of the head fifo character
// - overrun flag set on buffer overflow; software reads or clears, never sets
// - clearing a set overrun flag empties the buffer and resets the shift register
// - data available flag is 1 while a character waits, 0 when empty
module urs_uart_receive_status (
  // clock, reset, enable
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clkEn,
  // serial line from the remote transmitter
  input wire logic rxLine,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  // interrupt and address match pulse
  output logic irq,
  output logic addrCharSeen
);

  // ****************************************
  // types and state
  // ****************************************
  // receiver walks idle, start check, data bits, optional parity, stop
  // every register of the block lives in one packed struct
  // so the clock enable freezes all of it in one place
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP} urs_rx_state_t;

  typedef struct packed {
    urs_rx_state_t rxState;
    logic [15:0] bitCnt;
    logic [3:0] bitIdx;
    logic [8:0] shiftReg;
    logic parityErr;
    logic [urs_pkg::FIFO_DEPTH-1:0][urs_pkg::ENTRY_WIDTH-1:0] fifo;
    logic [urs_pkg::PTR_WIDTH:0] wrPtr;
    logic [urs_pkg::PTR_WIDTH:0] rdPtr;
    logic overrun;
    logic addrDetectEn;
    logic [1:0] charMode;
    logic [15:0] divisor;
    logic [urs_pkg::IRQ_WIDTH-1:0] intStatus;
    logic [urs_pkg::IRQ_WIDTH-1:0] intMask;
    logic [15:0] rdData;
    logic irqOut;
    logic addrPulse;
    logic rxSync1;
    logic rxSync2;
  } urs_state_t;

  urs_state_t state_ff;
  urs_state_t nxt_state;

  // ****************************************
  // mode decoding
  // ****************************************
  // both decodes are used by the data bit loop; the parity step checks for odd mode itself
  // number of data bits in a character for a mode
  function automatic logic [3:0] dataBits(input logic [1:0] mode);
    dataBits = (mode == urs_pkg::MODE_9BIT) ? 4'h9 : 4'h8;
  endfunction : dataBits

  // true when the mode carries a parity bit
  function automatic logic hasParity(input logic [1:0] mode);
    hasParity = (mode == urs_pkg::MODE_8BIT_EVEN) || (mode == urs_pkg::MODE_8BIT_ODD);
  endfunction : hasParity

  // ****************************************
  // fifo flags and status word
  // ****************************************
  // pointers carry one extra wrap bit so full and empty differ
  // head entry layout: framing error, parity error, nine data bits
  // error flags travel with the character, not with the receiver
  logic fifoEmpty;
  logic fifoFull;
  logic [urs_pkg::ENTRY_WIDTH-1:0] headEntry;
  logic [15:0] statusWord;
  logic halfBit;

  // fifo flags and head entry
  always_comb begin
    fifoEmpty = (state_ff.wrPtr == state_ff.rdPtr);
    fifoFull = (state_ff.wrPtr[urs_pkg::PTR_WIDTH-1:0] == state_ff.rdPtr[urs_pkg::PTR_WIDTH-1:0]) &&
               (state_ff.wrPtr[urs_pkg::PTR_WIDTH] != state_ff.rdPtr[urs_pkg::PTR_WIDTH]);
    headEntry = state_ff.fifo[state_ff.rdPtr[urs_pkg::PTR_WIDTH-1:0]];
    halfBit = (state_ff.bitCnt == {1'b0, state_ff.divisor[15:1]});
  end

  // status word as software sees it
  always_comb begin
    statusWord = 16'h0000;
    statusWord[urs_pkg::BIT_ADDR_DETECT_EN] = state_ff.addrDetectEn;
    statusWord[urs_pkg::BIT_RX_IDLE] = (state_ff.rxState == ST_IDLE);
    statusWord[urs_pkg::BIT_PARITY_ERR] = !fifoEmpty && headEntry[9];
    statusWord[urs_pkg::BIT_FRAMING_ERR] = !fifoEmpty && headEntry[10];
    statusWord[urs_pkg::BIT_OVERRUN] = state_ff.overrun;
    statusWord[urs_pkg::BIT_DATA_AVAIL] = !fifoEmpty;
  end

  // ****************************************
  // next state
  // ****************************************
  // line goes through two flip-flops before the receiver looks at it
  // a start is checked again at half a bit to reject short glitches
  // data, parity and stop bits are sampled at their centres
  // next state of the whole block
  always_comb begin
    logic stopOk;
    logic isAddr;
    logic pushReq;
    stopOk = 1'b0;
    isAddr = 1'b0;
    pushReq = 1'b0;
    nxt_state = state_ff;
    nxt_state.addrPulse = 1'b0;
    nxt_state.rxSync1 = rxLine;
    nxt_state.rxSync2 = state_ff.rxSync1;
    nxt_state.bitCnt = state_ff.bitCnt + 16'h0001;

    // receiver state machine, sampling at the bit centre
    case (state_ff.rxState)
      ST_IDLE: begin
        nxt_state.bitCnt = 16'h0000;
        if (!state_ff.rxSync2) begin
          nxt_state.rxState = ST_START;
        end
      end
      ST_START: begin
        if (halfBit) begin
          nxt_state.bitCnt = 16'h0000;
          nxt_state.bitIdx = 4'h0;
          nxt_state.parityErr = 1'b0;
          nxt_state.rxState = state_ff.rxSync2 ? ST_IDLE : ST_DATA;
        end
      end
      ST_DATA: begin
        if (state_ff.bitCnt == state_ff.divisor) begin
          nxt_state.bitCnt = 16'h0000;
          nxt_state.shiftReg = {state_ff.rxSync2, state_ff.shiftReg[8:1]};
          nxt_state.bitIdx = state_ff.bitIdx + 4'h1;
          if (state_ff.bitIdx == dataBits(state_ff.charMode) - 4'h1) begin
            if (state_ff.charMode != urs_pkg::MODE_9BIT) begin
              nxt_state.shiftReg = {1'b0, state_ff.rxSync2, state_ff.shiftReg[8:2]};
            end
            nxt_state.rxState = hasParity(state_ff.charMode) ? ST_PARITY : ST_STOP;
          end
        end
      end
      ST_PARITY: begin
        if (state_ff.bitCnt == state_ff.divisor) begin
          nxt_state.bitCnt = 16'h0000;
          nxt_state.parityErr = (^state_ff.shiftReg[7:0]) ^ state_ff.rxSync2 ^
                                (state_ff.charMode == urs_pkg::MODE_8BIT_ODD);
          nxt_state.rxState = ST_STOP;
        end
      end
      ST_STOP: begin
        if (state_ff.bitCnt == state_ff.divisor) begin
          stopOk = state_ff.rxSync2;
          isAddr = state_ff.addrDetectEn && (state_ff.charMode == urs_pkg::MODE_9BIT) &&
                   state_ff.shiftReg[urs_pkg::BIT_ADDR_MARK];
          pushReq = 1'b1;
          nxt_state.rxState = ST_IDLE;
        end
      end
      default: nxt_state.rxState = ST_IDLE;
    endcase

    // ****************************************
    // register access
    // ****************************************
    // read data is registered and shows in the cycle after the strobe
    // interrupt flags clear on read; a new event in that cycle still sets
    // register reads; a status read of the interrupt flags clears them
    if (regRead) begin
      case (regAddr)
        urs_pkg::ADDR_STATUS: nxt_state.rdData = statusWord;
        urs_pkg::ADDR_MODE: nxt_state.rdData = {14'h0000, state_ff.charMode};
        urs_pkg::ADDR_RXDATA: nxt_state.rdData = {7'h00, headEntry[8:0]} & {16{!fifoEmpty}};
        urs_pkg::ADDR_INT_STATUS: begin
          nxt_state.rdData = {12'h000, state_ff.intStatus};
          nxt_state.intStatus = '0;
        end
        urs_pkg::ADDR_INT_MASK: nxt_state.rdData = {12'h000, state_ff.intMask};
        default: nxt_state.rdData = 16'h0000;
      endcase
      // reading the data register pops the head and its error flags
      if (regAddr == urs_pkg::ADDR_RXDATA && !fifoEmpty) begin
        nxt_state.rdPtr = state_ff.rdPtr + {{urs_pkg::PTR_WIDTH{1'b0}}, 1'b1};
      end
    end

    // register writes
    if (regWrite) begin
      case (regAddr)
        urs_pkg::ADDR_STATUS: begin
          nxt_state.addrDetectEn = regWrData[urs_pkg::BIT_ADDR_DETECT_EN];
          // overrun can only be cleared by software
          if (!regWrData[urs_pkg::BIT_OVERRUN]) begin
            nxt_state.overrun = 1'b0;
            if (state_ff.overrun) begin
              // flush buffer and shift register on the 1 to 0 change
              nxt_state.rdPtr = state_ff.wrPtr;
              nxt_state.shiftReg = 9'h000;
              nxt_state.bitIdx = 4'h0;
              nxt_state.rxState = ST_IDLE;
              pushReq = 1'b0;
            end
          end
        end
        urs_pkg::ADDR_MODE: begin
          nxt_state.charMode = regWrData[1:0];
          nxt_state.divisor = state_ff.divisor;
        end
        urs_pkg::ADDR_INT_MASK: nxt_state.intMask = regWrData[urs_pkg::IRQ_WIDTH-1:0];
        default: nxt_state.divisor = state_ff.divisor;
      endcase
    end

    // ****************************************
    // fifo push and events
    // ****************************************
    // a pop in the same cycle frees a slot, so a full fifo still takes it
    // while overrun stands every new character is dropped until software clears it
    // push a finished character; a full fifo sets overrun and drops it
    if (pushReq) begin
      if (state_ff.overrun || (fifoFull && nxt_state.rdPtr == state_ff.rdPtr)) begin
        nxt_state.overrun = 1'b1;
        nxt_state.intStatus[urs_pkg::IRQ_OVERRUN] = 1'b1;
      end else begin
        nxt_state.fifo[state_ff.wrPtr[urs_pkg::PTR_WIDTH-1:0]] =
          {!stopOk, state_ff.parityErr, state_ff.shiftReg};
        nxt_state.wrPtr = state_ff.wrPtr + {{urs_pkg::PTR_WIDTH{1'b0}}, 1'b1};
        nxt_state.intStatus[urs_pkg::IRQ_RX_CHAR] = 1'b1;
        if (isAddr) begin
          nxt_state.intStatus[urs_pkg::IRQ_ADDR_CHAR] = 1'b1;
          nxt_state.addrPulse = 1'b1;
        end
        if (!stopOk || state_ff.parityErr) begin
          nxt_state.intStatus[urs_pkg::IRQ_ERROR] = 1'b1;
        end
      end
    end

    nxt_state.irqOut = |(nxt_state.intStatus & nxt_state.intMask);
  end

  // ****************************************
  // state register
  // ****************************************
  // reset puts the line synchroniser at the idle level of the pin
  // so no false start follows the release of reset
  // state register, frozen while the enable is low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '{rxState: ST_IDLE, bitCnt: 16'h0000, bitIdx: 4'h0, shiftReg: 9'h000,
                    parityErr: 1'b0, fifo: '0, wrPtr: '0, rdPtr: '0,
                    overrun: 1'b0, addrDetectEn: 1'b0, charMode: urs_pkg::MODE_8BIT_NONE,
                    divisor: urs_pkg::RESET_DIVISOR, intStatus: '0, intMask: '0,
                    rdData: 16'h0000, irqOut: 1'b0, addrPulse: 1'b0, rxSync1: 1'b1,
                    rxSync2: 1'b1};
    end else if (clkEn) begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // no logic between the state flip-flops and the pins
  // outputs straight from flip-flops
  always_comb begin
    regRdData = state_ff.rdData;
    irq = state_ff.irqOut;
    addrCharSeen = state_ff.addrPulse;
  end

endmodule : urs_uart_receive_status
`default_nettype wire

/* File: tb/urs_serial_tx.sv */
// remote serial transmitter model driving the receive line
`timescale 1ns/1ns
`default_nettype none
module urs_serial_tx #(
  parameter int BIT_CYCLES = 87 // divisor 0x56 plus one
) (
  // clock
  input wire logic clock,
  // serial line, idle high
  output var logic txLine
);
  initial txLine = 1'b1;
  // one frame: start, data lsb first, optional parity, stop level chosen by caller
  task automatic send(input logic [8:0] d, input int n, input int par, input logic bad, input logic stp);
    txLine <= 1'b0;
    repeat (BIT_CYCLES) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      txLine <= d[i];
      repeat (BIT_CYCLES) @(posedge clock);
    end
    if (par != 0) begin
      txLine <= ^d[7:0] ^ (par == 2) ^ bad;
      repeat (BIT_CYCLES) @(posedge clock);
    end
    txLine <= stp;
    repeat (BIT_CYCLES) @(posedge clock);
    txLine <= 1'b1;
    @(posedge clock);
  endtask : send
endmodule : urs_serial_tx
`default_nettype wire

/* File: tb/urs_uart_receive_status_chk.sv */
// port checker of the uart receive status block
`timescale 1ns/1ns
`default_nettype none
module urs_uart_receive_status_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // serial and register side
  input wire logic clkEn,
  input wire logic rxLine,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regRdData,
  input wire logic irq,
  input wire logic addrCharSeen
);
  logic nineMode_ff;
  logic addrEn_ff;
  wire logic stRd = regRead && (regAddr == urs_pkg::ADDR_STATUS);
  wire logic stWr = regWrite && (regAddr == urs_pkg::ADDR_STATUS);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // shadow of mode and detect enable writes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nineMode_ff <= 1'b0;
      addrEn_ff <= 1'b0;
    end else if (regWrite && clkEn) begin
      if (regAddr == urs_pkg::ADDR_MODE) nineMode_ff <= (regWrData[1:0] == urs_pkg::MODE_9BIT);
      if (stWr) addrEn_ff <= regWrData[5];
    end
  end
  chk_addr_pulse: assert property (addrCharSeen |-> rxLine ##1 !addrCharSeen)
    else $error("address pulse wrong");
  chk_addr_mode: assert property (addrCharSeen |-> nineMode_ff && addrEn_ff)
    else $error("address pulse outside detect mode");
  chk_idle_busy: assert property (stRd && !$past(rxLine, 4) && !$past(rxLine, 5) |=> !regRdData[4])
    else $error("idle flag set while receiving");
  chk_parity_empty: assert property (stRd ##1 !regRdData[0] |-> !regRdData[3])
    else $error("parity flag without character");
  chk_frame_empty: assert property (stRd ##1 !regRdData[0] |-> !regRdData[2])
    else $error("framing flag without character");
  chk_ovr_noset: assert property (stRd ##2 (!regRdData[1] && stWr && regWrData[1]) ##1 stRd |=> !regRdData[1])
    else $error("overrun set by write");
  chk_ovr_clear: assert property (stWr && !regWrData[1] ##1 stRd |=> !regRdData[1])
    else $error("overrun not cleared");
  chk_empty_pop: assert property (stRd ##2 (!regRdData[0] && regRead && regAddr == urs_pkg::ADDR_RXDATA) |=> regRdData == 16'h0000)
    else $error("data from empty buffer");
endmodule : urs_uart_receive_status_chk
bind urs_uart_receive_status urs_uart_receive_status_chk urs_uart_receive_status_chk_i (.clock(clock), .rst_n(rst_n),
  .clkEn(clkEn), .rxLine(rxLine), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
  .regRead(regRead), .regRdData(regRdData), .irq(irq), .addrCharSeen(addrCharSeen));
`default_nettype wire

/* File: tb/urs_uart_receive_status_tb.sv */
// register level testbench of the uart receive status block
`timescale 1ns/1ns
`default_nettype none
module urs_uart_receive_status_tb;
  logic clock;
  logic rst_n;
  logic clkEn;
  wire logic rxLine;
  logic [3:0] regAddr;
  logic [15:0] regWrData;
  logic regWrite;
  logic regRead;
  logic [15:0] regRdData;
  logic irq;
  logic addrCharSeen;
  int failCount;
  int nCompared;
  int nAddr;
  // design and far side transmitter
  urs_uart_receive_status urs_uart_receive_status_i (.clock(clock), .rst_n(rst_n), .clkEn(clkEn), .rxLine(rxLine),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .irq(irq), .addrCharSeen(addrCharSeen));
  urs_serial_tx urs_serial_tx_i (.clock(clock), .txLine(rxLine));
  // *****************************
  // tasks
  // *****************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    nCompared++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    chk(regRdData, exp, what);
    @(posedge clock);
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr
  task automatic testDone;
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : testDone
  // clock, watchdog and address pulse count
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    repeat (100000) @(posedge clock);
    failCount++;
    testDone();
  end
  always @(posedge clock) if (addrCharSeen === 1'b1) nAddr++;
  // *****************************
  // main sequence
  // *****************************
  initial begin
    {rst_n, regAddr, regWrData, regWrite, regRead} = '0;
    clkEn = 1'b1;
    failCount = 0;
    nCompared = 0;
    nAddr = 0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(4'hF, 16'h0000, "unmapped");
    rd(urs_pkg::ADDR_STATUS, 16'h0010, "status at reset");
    wr(urs_pkg::ADDR_STATUS, 16'h0002);
    rd(urs_pkg::ADDR_STATUS, 16'h0010, "overrun write");
    wr(urs_pkg::ADDR_MODE, 16'h0001);
    rd(urs_pkg::ADDR_STATUS, 16'h0010, "even mode");
    wr(urs_pkg::ADDR_INT_MASK, 16'h0001);
    $display("test reset done");
    fork
      urs_serial_tx_i.send(9'h055, 8, 1, 1'b0, 1'b1);
      begin
        repeat (50) @(posedge clock);
        rd(urs_pkg::ADDR_STATUS, 16'h0000, "busy status");
      end
    join
    chk({15'h0000, irq}, 16'h0001, "irq raised");
    urs_serial_tx_i.send(9'h0A3, 8, 1, 1'b1, 1'b1);
    rd(urs_pkg::ADDR_STATUS, 16'h0011, "head good parity");
    rd(urs_pkg::ADDR_INT_STATUS, 16'h0009, "events");
    rd(urs_pkg::ADDR_RXDATA, 16'h0055, "first char");
    chk({15'h0000, irq}, 16'h0000, "irq cleared");
    rd(urs_pkg::ADDR_STATUS, 16'h0019, "head bad parity");
    rd(urs_pkg::ADDR_RXDATA, 16'h00A3, "second char");
    rd(urs_pkg::ADDR_STATUS, 16'h0010, "drained");
    rd(urs_pkg::ADDR_RXDATA, 16'h0000, "empty pop");
    $display("test parity done");
    wr(urs_pkg::ADDR_MODE, 16'h0000);
    urs_serial_tx_i.send(9'h03C, 8, 0, 1'b0, 1'b0);
    // low stop looks like a new start; let the half bit check reject it
    repeat (60) @(posedge clock);
    rd(urs_pkg::ADDR_STATUS, 16'h0015, "framing head");
    rd(urs_pkg::ADDR_RXDATA, 16'h003C, "framed char");
    $display("test framing done");
    wr(urs_pkg::ADDR_MODE, 16'h0003);
    rd(urs_pkg::ADDR_STATUS, 16'h0010, "nine bit mode");
    wr(urs_pkg::ADDR_STATUS, 16'h0020);
    urs_serial_tx_i.send(9'h1A5, 9, 0, 1'b0, 1'b1);
    urs_serial_tx_i.send(9'h0A5, 9, 0, 1'b0, 1'b1);
    chk(nAddr[15:0], 16'h0001, "address pulses");
    wr(urs_pkg::ADDR_MODE, 16'h0000);
    urs_serial_tx_i.send(9'h1A5, 8, 0, 1'b0, 1'b1);
    rd(urs_pkg::ADDR_STATUS, 16'h0031, "eight bit detect");
    wr(urs_pkg::ADDR_STATUS, 16'h0000);
    rd(urs_pkg::ADDR_STATUS, 16'h0011, "detect off");
    wr(urs_pkg::ADDR_MODE, 16'h0003);
    urs_serial_tx_i.send(9'h1A5, 9, 0, 1'b0, 1'b1);
    chk(nAddr[15:0], 16'h0001, "detect disabled");
    $display("test address done");
    wr(urs_pkg::ADDR_INT_MASK, 16'h0000);
    urs_serial_tx_i.send(9'h011, 9, 0, 1'b0, 1'b1);
    rd(urs_pkg::ADDR_STATUS, 16'h0013, "overrun set");
    chk({15'h0000, irq}, 16'h0000, "irq masked");
    wr(urs_pkg::ADDR_STATUS, 16'h0000);
    rd(urs_pkg::ADDR_STATUS, 16'h0010, "overrun cleared");
    rd(urs_pkg::ADDR_RXDATA, 16'h0000, "flushed");
    $display("test overrun done");
    clkEn <= 1'b0;
    rd(urs_pkg::ADDR_STATUS, 16'h0000, "frozen read");
    clkEn <= 1'b1;
    rd(urs_pkg::ADDR_STATUS, 16'h0010, "enabled read");
    $display("test enable done");
    testDone();
  end
endmodule : urs_uart_receive_status_tb
`default_nettype wire
